// >>> common/dirb_pkg.sv
`default_nettype none
package dirb_pkg;
  // Index offsets of the bank.
  localparam logic [7:0] DIRB_IDX_CLK_PRI      = 8'h54;
  localparam logic [7:0] DIRB_IDX_PAL_INDEX    = 8'h60;
  localparam logic [7:0] DIRB_IDX_PF_INDEX_LO  = 8'h62;
  localparam logic [7:0] DIRB_IDX_PF_INDEX_HI  = 8'h63;
  localparam logic [7:0] DIRB_IDX_PAL_DATA     = 8'h65;
  localparam logic [7:0] DIRB_IDX_PAL_SEQ      = 8'h66;
  localparam logic [7:0] DIRB_IDX_PAL_RED_SH   = 8'h67;
  localparam logic [7:0] DIRB_IDX_PAL_GREEN_SH = 8'h68;
  localparam logic [7:0] DIRB_IDX_PAL_BLUE_SH  = 8'h69;
  localparam logic [7:0] DIRB_IDX_SPR_DATA     = 8'h6a;
  localparam logic [7:0] DIRB_IDX_SPR_SH       = 8'h6b;
  localparam logic [7:0] DIRB_IDX_DAC_BLANK    = 8'h6c;
  localparam logic [7:0] DIRB_IDX_TERM_CURSOR  = 8'h6d;
  localparam logic [7:0] DIRB_IDX_CLK_SEC      = 8'h70;
  // Field positions.
  localparam int DIRB_POS_PROG_CLK      = 7;
  localparam int DIRB_POS_CLK_HIGH      = 7;
  localparam int DIRB_POS_CLK_LOW_HI    = 3;
  localparam int DIRB_POS_CLK_LOW_LO    = 2;
  localparam int DIRB_POS_DIV_HI        = 1;
  localparam int DIRB_POS_DIV_LO        = 0;
  localparam int DIRB_POS_ELEM_ORDER    = 2;
  localparam int DIRB_POS_RB_BLANK      = 0;
  localparam int DIRB_POS_CCOL_HI       = 7;
  localparam int DIRB_POS_CCOL_LO       = 4;
  localparam int DIRB_POS_CONST_CCOL    = 3;
  localparam int DIRB_POS_BLINK_DIS     = 2;
  localparam int DIRB_POS_REV_SEL       = 1;
  localparam int DIRB_POS_ATTR_EN       = 0;
  // Reset values.
  localparam logic [7:0]  DIRB_RST_BYTE  = 8'h00;
  localparam logic [13:0] DIRB_RST_INDEX = 14'h0000;
  // Palette element codes.
  typedef enum logic [1:0] {
    DIRB_ELEM_RED   = 2'h0,
    DIRB_ELEM_GREEN = 2'h1,
    DIRB_ELEM_BLUE  = 2'h2,
    DIRB_ELEM_DISC  = 2'h3
  } dirb_elem_t;
  // Video clock sources, one-hot.
  typedef enum logic [6:0] {
    DIRB_CLK_TEXT8   = 7'h01,
    DIRB_CLK_TEXT9   = 7'h02,
    DIRB_CLK_EXT     = 7'h04,
    DIRB_CLK_HIRES   = 7'h08,
    DIRB_CLK_COL132  = 7'h10,
    DIRB_CLK_PROG    = 7'h20,
    DIRB_CLK_RSVD    = 7'h40
  } dirb_clk_t;
  localparam logic [1:0] DIRB_DIV_BY1 = 2'h0;
  localparam logic [1:0] DIRB_DIV_BY2 = 2'h1;
endpackage : dirb_pkg
`default_nettype wire

// >>> hw/dirb_bank.sv
// Overview of operation
// RULE1 - Element select 01 picks green, 10 picks blue, 11 a discarded slot.
// RULE2 - Element select 00 presents the red element through the palette data register.
// RULE3 - Order bit 0 steps R,G,B; bit 1 steps R,B,G then discarded slot.
// RULE4 - Interrupting code saves and restores palette and sprite shadow registers.
// RULE5 - Writing low prefetch index loads palette shadows then increments index.
// RULE6 - Sprite data mirrors the selected sprite location; reads may differ from writes.
// RULE7 - Sprite data bytes are packed pixels, little-endian pixel order.
// RULE8 - Red/blue blank bit set forces red and blue DAC outputs to zero.
// RULE9 - Software should set red/blue blank for monochrome displays.
// RULE10 - Cursor control register is accessible only while host terminal function enabled.
// RULE11 - Constant cursor colour set: cursor uses four-bit colour field, IRGB coded.
// RULE12 - Constant cursor colour clear: cursor takes cell foreground colour.
// RULE13 - Blink disable set gives steady cursor; clear blinks at terminal rate.
// RULE14 - Cursor type 0 forces foreground; 1 forces reverse video.
// RULE15 - Attribute enable 0 gives standard attributes; other cursor fields inert.
// RULE16 - Clock pick built from programmable bit, high pick bit and low pick field.
// RULE17 - With both upper bits 0, low field picks text8, text9, external, hi-res clock.
// RULE18 - High pick with 00 selects 132-column clock; programmable with 00 programmed clock.
// RULE19 - Divider field 00 divides by one, 01 by two; others reserved.
// RULE20 - All registers reset to zero; reserved bits written zero.
//
// Chosen here: strobed register access.
`default_nettype none
module dirb_bank #(
  parameter int SPR_AW = 14
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Mode input from the operating mode register
  input  wire logic               host_terminal_function,
  // Palette RAM port, one element per write, whole entry per read
  output logic [7:0]              pal_addr,
  output logic [1:0]              pal_elem,
  output logic                    pal_we,
  output logic [7:0]              pal_wdata,
  input  wire logic [23:0]        pal_rdata,
  // Sprite buffer port
  output logic [SPR_AW-1:0]       spr_addr,
  output logic                    spr_we,
  output logic [7:0]              spr_wdata,
  input  wire logic [7:0]         spr_rdata,
  // DAC inputs and outputs
  input  wire logic [7:0]         dac_red_in,
  input  wire logic [7:0]         dac_green_in,
  input  wire logic [7:0]         dac_blue_in,
  output logic [7:0]              dac_red_out,
  output logic [7:0]              dac_green_out,
  output logic [7:0]              dac_blue_out,
  // Cursor controls to the attribute stage
  output logic                    terminal_attribute_enable,
  output logic                    constant_cursor_colour,
  output logic [3:0]              cursor_colour,
  output logic                    cursor_blink_disable,
  output logic                    cursor_reverse_select,
  // Video clock selection to the CRT controller
  output logic [6:0]              video_clock_select,
  output logic [1:0]              video_clock_divider
);
  import dirb_pkg::*;

  logic [7:0]        clk_pri_ff;
  logic [7:0]        clk_sec_ff;
  logic [1:0]        pal_seq_ff;
  logic [7:0]        pal_index_ff;
  logic [SPR_AW-1:0] pf_index_ff;
  logic [7:0]        pal_red_sh_ff;
  logic [7:0]        pal_green_sh_ff;
  logic [7:0]        pal_blue_sh_ff;
  logic [7:0]        spr_sh_ff;
  logic              rb_blank_ff;
  logic [7:0]        cursor_ff;
  logic [3:0]        cur_col_ff;
  logic              attr_en_ff;
  logic              const_col_ff;
  logic              blink_dis_ff;
  logic              rev_sel_ff;
  logic [1:0]        elem_ff;
  logic [7:0]        reg_rdata_ff;
  logic [7:0]        pal_addr_ff;
  logic [1:0]        pal_elem_ff;
  logic              pal_we_ff;
  logic [7:0]        pal_wdata_ff;
  logic [SPR_AW-1:0] spr_addr_ff;
  logic              spr_we_ff;
  logic [7:0]        spr_wdata_ff;
  logic              pal_load_ff;
  logic              spr_load_ff;
  logic [7:0]        dac_red_ff;
  logic [7:0]        dac_green_ff;
  logic [7:0]        dac_blue_ff;
  logic [6:0]        clk_sel_ff;
  logic [1:0]        nxt_elem;
  logic [6:0]        nxt_clk_sel;
  logic              pal_touch;
  logic              pf_lo_wr;
  logic              pf_hi_wr;
  logic              cursor_open;
  logic [7:0]        pal_elem_byte;

  assign pal_touch   = (reg_wr || reg_rd) && reg_addr == DIRB_IDX_PAL_DATA;
  assign pf_lo_wr    = reg_wr && reg_addr == DIRB_IDX_PF_INDEX_LO;
  assign pf_hi_wr    = reg_wr && reg_addr == DIRB_IDX_PF_INDEX_HI;
  assign cursor_open = host_terminal_function; // RULE10

  // Next element after a palette data access; order bit picks the walk.
  always_comb begin
    nxt_elem = elem_ff;
    if (pal_touch) begin
      if (!pal_seq_ff[0]) begin // RULE3
        case (elem_ff)
          DIRB_ELEM_RED:   nxt_elem = DIRB_ELEM_GREEN;
          DIRB_ELEM_GREEN: nxt_elem = DIRB_ELEM_BLUE;
          default:         nxt_elem = DIRB_ELEM_RED;
        endcase
      end else begin
        case (elem_ff)
          DIRB_ELEM_RED:  nxt_elem = DIRB_ELEM_BLUE;
          DIRB_ELEM_BLUE: nxt_elem = DIRB_ELEM_GREEN;
          DIRB_ELEM_GREEN: nxt_elem = DIRB_ELEM_DISC;
          default:        nxt_elem = DIRB_ELEM_RED;
        endcase
      end
    end
    if (reg_wr && reg_addr == DIRB_IDX_PAL_SEQ) begin
      nxt_elem = reg_wdata[1:0];
    end
  end

  // The current element byte presented by the palette data register.
  always_comb begin
    case (elem_ff)
      DIRB_ELEM_RED:   pal_elem_byte = pal_red_sh_ff; // RULE2
      DIRB_ELEM_GREEN: pal_elem_byte = pal_green_sh_ff; // RULE1
      DIRB_ELEM_BLUE:  pal_elem_byte = pal_blue_sh_ff; // RULE1
      default:         pal_elem_byte = DIRB_RST_BYTE; // RULE1
    endcase
  end

  // Clock source decode; any reserved code selects nothing usable.
  always_comb begin
    nxt_clk_sel = DIRB_CLK_RSVD;
    case ({clk_pri_ff[DIRB_POS_PROG_CLK], clk_sec_ff[DIRB_POS_CLK_HIGH]}) // RULE16
      2'h0: begin
        case (clk_pri_ff[DIRB_POS_CLK_LOW_HI:DIRB_POS_CLK_LOW_LO]) // RULE17
          2'h0:    nxt_clk_sel = DIRB_CLK_TEXT8;
          2'h1:    nxt_clk_sel = DIRB_CLK_TEXT9;
          2'h2:    nxt_clk_sel = DIRB_CLK_EXT;
          default: nxt_clk_sel = DIRB_CLK_HIRES;
        endcase
      end
      2'h1: begin
        if (clk_pri_ff[DIRB_POS_CLK_LOW_HI:DIRB_POS_CLK_LOW_LO] == 2'h0) begin
          nxt_clk_sel = DIRB_CLK_COL132; // RULE18
        end
      end
      2'h2: begin
        if (clk_pri_ff[DIRB_POS_CLK_LOW_HI:DIRB_POS_CLK_LOW_LO] == 2'h0) begin
          nxt_clk_sel = DIRB_CLK_PROG; // RULE18
        end
      end
      default: nxt_clk_sel = DIRB_CLK_RSVD;
    endcase
  end

  // Plain control registers.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clk_pri_ff   <= DIRB_RST_BYTE; // RULE20
      clk_sec_ff   <= DIRB_RST_BYTE;
      pal_seq_ff   <= 2'h0;
      pal_index_ff <= DIRB_RST_BYTE;
      rb_blank_ff  <= 1'b0;
      cursor_ff    <= DIRB_RST_BYTE;
      cur_col_ff   <= 4'h0;
      attr_en_ff   <= 1'b0;
      const_col_ff <= 1'b0;
      blink_dis_ff <= 1'b0;
      rev_sel_ff   <= 1'b0;
      elem_ff      <= DIRB_ELEM_RED;
    end else begin
      elem_ff <= nxt_elem;
      if (reg_wr) begin
        case (reg_addr)
          DIRB_IDX_CLK_PRI:     clk_pri_ff   <= reg_wdata;
          DIRB_IDX_CLK_SEC:     clk_sec_ff   <= reg_wdata & 8'h80; // RULE20
          DIRB_IDX_PAL_INDEX:   pal_index_ff <= reg_wdata;
          DIRB_IDX_PAL_SEQ:     pal_seq_ff   <= {1'b0, reg_wdata[DIRB_POS_ELEM_ORDER]};
          DIRB_IDX_DAC_BLANK:   rb_blank_ff  <= reg_wdata[DIRB_POS_RB_BLANK];
          DIRB_IDX_TERM_CURSOR: begin
            if (cursor_open) begin
              cursor_ff    <= reg_wdata; // RULE10
              // With attributes disabled the constant colour, blink and reverse fields read as inactive downstream; the colour field passes through.
              cur_col_ff   <= reg_wdata[DIRB_POS_CCOL_HI:DIRB_POS_CCOL_LO]; // RULE11
              attr_en_ff   <= reg_wdata[DIRB_POS_ATTR_EN]; // RULE15
              const_col_ff <= reg_wdata[DIRB_POS_CONST_CCOL] & reg_wdata[DIRB_POS_ATTR_EN]; // RULE11 RULE12
              blink_dis_ff <= reg_wdata[DIRB_POS_BLINK_DIS] & reg_wdata[DIRB_POS_ATTR_EN]; // RULE13
              rev_sel_ff   <= reg_wdata[DIRB_POS_REV_SEL] & reg_wdata[DIRB_POS_ATTR_EN]; // RULE14
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Prefetch index and shadows; a low-index write loads then increments.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pf_index_ff     <= DIRB_RST_INDEX[SPR_AW-1:0];
      pal_red_sh_ff   <= DIRB_RST_BYTE;
      pal_green_sh_ff <= DIRB_RST_BYTE;
      pal_blue_sh_ff  <= DIRB_RST_BYTE;
      spr_sh_ff       <= DIRB_RST_BYTE;
      pal_load_ff     <= 1'b0;
      spr_load_ff     <= 1'b0;
    end else begin
      pal_load_ff <= pf_lo_wr;
      spr_load_ff <= pf_lo_wr || pf_hi_wr;
      if (pf_lo_wr) begin
        pf_index_ff[7:0] <= reg_wdata;
      end else if (pf_hi_wr) begin
        pf_index_ff[SPR_AW-1:8] <= reg_wdata[SPR_AW-9:0];
      end
      // The RAM answers one cycle after the index settles.
      if (pal_load_ff) begin
        pal_red_sh_ff   <= pal_rdata[23:16]; // RULE5
        pal_green_sh_ff <= pal_rdata[15:8];
        pal_blue_sh_ff  <= pal_rdata[7:0];
        pf_index_ff     <= pf_index_ff + SPR_AW'(1); // RULE5
      end
      if (spr_load_ff) begin
        spr_sh_ff <= spr_rdata; // RULE6
        if (!pal_load_ff) begin
          pf_index_ff <= pf_index_ff + SPR_AW'(1);
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          DIRB_IDX_PAL_RED_SH:   pal_red_sh_ff   <= reg_wdata; // RULE4
          DIRB_IDX_PAL_GREEN_SH: pal_green_sh_ff <= reg_wdata;
          DIRB_IDX_PAL_BLUE_SH:  pal_blue_sh_ff  <= reg_wdata;
          DIRB_IDX_SPR_SH:       spr_sh_ff       <= reg_wdata; // RULE4
          default: ;
        endcase
      end
    end
  end

  // Palette and sprite write ports.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pal_addr_ff  <= DIRB_RST_BYTE;
      pal_elem_ff  <= DIRB_ELEM_RED;
      pal_we_ff    <= 1'b0;
      pal_wdata_ff <= DIRB_RST_BYTE;
      spr_addr_ff  <= DIRB_RST_INDEX[SPR_AW-1:0];
      spr_we_ff    <= 1'b0;
      spr_wdata_ff <= DIRB_RST_BYTE;
    end else begin
      pal_addr_ff  <= (pf_lo_wr || pal_load_ff) ? (pf_lo_wr ? reg_wdata : pf_index_ff[7:0]) : pal_index_ff;
      pal_elem_ff  <= elem_ff;
      // Writes to the discarded slot never reach the RAM.
      pal_we_ff    <= reg_wr && reg_addr == DIRB_IDX_PAL_DATA && elem_ff != DIRB_ELEM_DISC; // RULE1
      pal_wdata_ff <= reg_wdata;
      // The buffer must see a freshly written index at once, or the prefetch reads the old location.
      spr_addr_ff  <= pf_lo_wr ? {pf_index_ff[SPR_AW-1:8], reg_wdata} :
                      pf_hi_wr ? {reg_wdata[SPR_AW-9:0], pf_index_ff[7:0]} : pf_index_ff; // RULE6
      // Bytes pass unchanged; pixel zero sits in the low bits.
      spr_we_ff    <= reg_wr && reg_addr == DIRB_IDX_SPR_DATA; // RULE7
      spr_wdata_ff <= reg_wdata; // RULE7
    end
  end

  // Read data, one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= DIRB_RST_BYTE;
    end else begin
      reg_rdata_ff <= DIRB_RST_BYTE;
      if (reg_rd) begin
        case (reg_addr)
          DIRB_IDX_CLK_PRI:      reg_rdata_ff <= clk_pri_ff;
          DIRB_IDX_CLK_SEC:      reg_rdata_ff <= clk_sec_ff;
          DIRB_IDX_PAL_INDEX:    reg_rdata_ff <= pal_index_ff;
          DIRB_IDX_PF_INDEX_LO:  reg_rdata_ff <= pf_index_ff[7:0];
          DIRB_IDX_PF_INDEX_HI:  reg_rdata_ff <= 8'(pf_index_ff[SPR_AW-1:8]);
          DIRB_IDX_PAL_DATA:     reg_rdata_ff <= pal_elem_byte;
          DIRB_IDX_PAL_SEQ:      reg_rdata_ff <= {5'h00, pal_seq_ff[0], elem_ff};
          DIRB_IDX_PAL_RED_SH:   reg_rdata_ff <= pal_red_sh_ff;
          DIRB_IDX_PAL_GREEN_SH: reg_rdata_ff <= pal_green_sh_ff;
          DIRB_IDX_PAL_BLUE_SH:  reg_rdata_ff <= pal_blue_sh_ff;
          DIRB_IDX_SPR_DATA:     reg_rdata_ff <= spr_sh_ff; // RULE6
          DIRB_IDX_SPR_SH:       reg_rdata_ff <= spr_sh_ff;
          DIRB_IDX_DAC_BLANK:    reg_rdata_ff <= {7'h00, rb_blank_ff};
          DIRB_IDX_TERM_CURSOR:  reg_rdata_ff <= cursor_open ? cursor_ff : DIRB_RST_BYTE; // RULE10
          default:               reg_rdata_ff <= DIRB_RST_BYTE;
        endcase
      end
    end
  end

  // Video path outputs.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_red_ff   <= DIRB_RST_BYTE;
      dac_green_ff <= DIRB_RST_BYTE;
      dac_blue_ff  <= DIRB_RST_BYTE;
      clk_sel_ff   <= DIRB_CLK_TEXT8;
    end else begin
      dac_red_ff   <= rb_blank_ff ? DIRB_RST_BYTE : dac_red_in; // RULE8
      dac_green_ff <= dac_green_in;
      dac_blue_ff  <= rb_blank_ff ? DIRB_RST_BYTE : dac_blue_in; // RULE8
      clk_sel_ff   <= nxt_clk_sel;
    end
  end

  assign reg_rdata                 = reg_rdata_ff;
  assign pal_addr                  = pal_addr_ff;
  assign pal_elem                  = pal_elem_ff;
  assign pal_we                    = pal_we_ff;
  assign pal_wdata                 = pal_wdata_ff;
  assign spr_addr                  = spr_addr_ff;
  assign spr_we                    = spr_we_ff;
  assign spr_wdata                 = spr_wdata_ff;
  assign dac_red_out               = dac_red_ff;
  assign dac_green_out             = dac_green_ff;
  assign dac_blue_out              = dac_blue_ff;
  assign terminal_attribute_enable = attr_en_ff; // RULE15
  assign constant_cursor_colour    = const_col_ff; // RULE11 RULE12
  assign cursor_colour             = cur_col_ff; // RULE11
  assign cursor_blink_disable      = blink_dis_ff; // RULE13
  assign cursor_reverse_select     = rev_sel_ff; // RULE14
  assign video_clock_select        = clk_sel_ff;
  assign video_clock_divider       = clk_pri_ff[DIRB_POS_DIV_HI:DIRB_POS_DIV_LO]; // RULE19
endmodule : dirb_bank
`default_nettype wire

// >>> dv/dirb_bank_assertions.sv
`default_nettype none
module dirb_bank_chk
  import dirb_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       host_terminal_function,
  // Palette, sprite and DAC side
  input wire logic [7:0] pal_addr,
  input wire logic       pal_we,
  input wire logic [7:0] pal_wdata,
  input wire logic       spr_we,
  input wire logic [7:0] spr_wdata,
  input wire logic [7:0] dac_red_out,
  input wire logic [7:0] dac_blue_out,
  // Cursor and clock selection
  input wire logic       terminal_attribute_enable,
  input wire logic       constant_cursor_colour,
  input wire logic [3:0] cursor_colour,
  input wire logic       cursor_blink_disable,
  input wire logic       cursor_reverse_select,
  input wire logic [6:0] video_clock_select,
  input wire logic [1:0] video_clock_divider
);
  timeunit 1ns;
  timeprecision 1ns;
  // Indexed by {programmable bit, high pick bit, low pick field}.
  localparam logic [6:0] CLK_TAB [16] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h40, 7'h40, 7'h40,
                                          7'h20, 7'h40, 7'h40, 7'h40, 7'h40, 7'h40, 7'h40, 7'h40};
  logic [7:0] pri_ff;
  logic       sec_ff;
  logic       blank_ff;
  logic [1:0] el_ff;
  logic       ord_ff;

  // Palette element walk, kept apart so a write into the discarded slot is judged from the order rules.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      el_ff  <= 2'h0;
      ord_ff <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h66) begin
      el_ff  <= reg_wdata[1:0];
      ord_ff <= reg_wdata[2];
    end else if ((reg_wr || reg_rd) && reg_addr == 8'h65) begin
      el_ff <= ord_ff ? ((el_ff == 2'h0) ? 2'h2 : (el_ff == 2'h2) ? 2'h1 : (el_ff == 2'h1) ? 2'h3 : 2'h0)
                      : ((el_ff == 2'h0) ? 2'h1 : (el_ff == 2'h1) ? 2'h2 : 2'h0);
    end
  end

  // Private copies of the steering registers, so checks do not depend on read-back.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pri_ff   <= 8'h00;
      sec_ff   <= 1'b0;
      blank_ff <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h54) pri_ff <= reg_wdata;
      if (reg_addr == 8'h70) sec_ff <= reg_wdata[7];
      if (reg_addr == 8'h6c) blank_ff <= reg_wdata[0];
    end
  end

  function automatic logic [7:0] cur_exp(input logic [7:0] v);
    return v[0] ? v : {v[7:4], 4'h0};
  endfunction : cur_exp

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_clock_pick_decode: assert property ($stable(pri_ff) && $stable(sec_ff) |->
    video_clock_select == CLK_TAB[{pri_ff[7], sec_ff, pri_ff[3:2]}] && video_clock_divider == pri_ff[1:0])
    else $error("video clock select or divider disagrees with the select registers");
  a_blank_forces_zero: assert property (blank_ff && $past(blank_ff) |->
    dac_red_out == 8'h00 && dac_blue_out == 8'h00) else $error("red or blue output not blanked");
  a_cursor_fields_gated: assert property (reg_wr && reg_addr == 8'h6d && host_terminal_function |->
    ##2 {cursor_colour, constant_cursor_colour, cursor_blink_disable, cursor_reverse_select,
    terminal_attribute_enable} == cur_exp($past(reg_wdata, 2))) else $error("cursor outputs wrong after write");
  a_cursor_write_refused: assert property (reg_wr && reg_addr == 8'h6d && !host_terminal_function |=>
    $stable({cursor_colour, terminal_attribute_enable}) [*2]) else $error("cursor register took a refused write");
  a_cursor_read_refused: assert property (reg_rd && reg_addr == 8'h6d && !host_terminal_function |=>
    reg_rdata == 8'h00) else $error("cursor register readable while disabled");
  a_prefetch_addr_load: assert property (reg_wr && reg_addr == 8'h62 |=>
    pal_addr == $past(reg_wdata)) else $error("prefetch did not address the palette");
  a_palette_write_pulse: assert property (reg_wr && reg_addr == 8'h65 |=>
    pal_we == ($past(el_ff) != 2'h3) && pal_wdata == $past(reg_wdata)) else $error("palette write not passed on");
  a_sprite_write_pulse: assert property (reg_wr && reg_addr == 8'h6a |=>
    spr_we && spr_wdata == $past(reg_wdata)) else $error("sprite write not passed on");
  a_read_data_window: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present outside its cycle");

  c_blank_set: cover property (reg_wr && reg_addr == 8'h6c && reg_wdata[0]);
  c_palette_pair: cover property (pal_we ##2 pal_we);
  c_clock_change: cover property ($changed(video_clock_select));
endmodule : dirb_bank_chk

bind dirb_bank dirb_bank_chk u_dirb_bank_chk (.*);
`default_nettype wire

// >>> dv/tb_dirb_bank.sv
`default_nettype none
module tb_dirb_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        resetn, reg_wr, reg_rd, host_terminal_function, pal_we, spr_we;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, pal_addr, pal_wdata, spr_wdata, spr_rdata;
  logic [7:0]  dac_red_in, dac_green_in, dac_blue_in, dac_red_out, dac_green_out, dac_blue_out;
  logic [1:0]  pal_elem, video_clock_divider;
  logic        terminal_attribute_enable, constant_cursor_colour, cursor_blink_disable, cursor_reverse_select;
  logic [3:0]  cursor_colour;
  logic [6:0]  video_clock_select;
  logic [13:0] spr_addr;
  logic [23:0] pal_rdata;
  int          n_compared = 0;
  int          fail_count = 0;

  always #25 clk_sys = ~clk_sys;

  dirb_bank u_dirb_bank (
    .clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_terminal_function,
    .pal_addr, .pal_elem, .pal_we, .pal_wdata, .pal_rdata, .spr_addr, .spr_we, .spr_wdata, .spr_rdata,
    .dac_red_in, .dac_green_in, .dac_blue_in, .dac_red_out, .dac_green_out, .dac_blue_out,
    .terminal_attribute_enable, .constant_cursor_colour, .cursor_colour, .cursor_blink_disable,
    .cursor_reverse_select, .video_clock_select, .video_clock_divider
  );

  // Stand-in memories: palette entries differ per address and sprite entries per low address byte, so a wrong address shows up as wrong data.
  assign pal_rdata = {pal_addr, ~pal_addr, pal_addr ^ 8'h5a};
  assign spr_rdata = spr_addr[7:0] ^ 8'h3c;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  // Video outputs are registered behind the register, so they lag a write by one more edge.
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  function automatic logic [7:0] cur();
    return {cursor_colour, constant_cursor_colour, cursor_blink_disable, cursor_reverse_select,
            terminal_attribute_enable};
  endfunction : cur

  task automatic t_reset;
    logic [7:0] a [7] = '{8'h54, 8'h67, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h70};
    foreach (a[i]) rd(a[i], 8'h00, "reset value");
    chk("reset clock", 8'h01, {1'b0, video_clock_select});
    $display("test reset done");
  endtask : t_reset

  task automatic t_clock;
    logic [23:0] t [8] = '{24'h000001, 24'h050002, 24'h080004, 24'h0d0008,
                           24'h01ff10, 24'h800020, 24'h840040, 24'h048040};
    foreach (t[i]) begin
      wr(8'h54, t[i][23:16]);
      wr(8'h70, t[i][15:8]);
      settle;
      chk("clock source", t[i][7:0], {1'b0, video_clock_select});
      chk("clock divider", {6'h00, t[i][17:16]}, {6'h00, video_clock_divider});
    end
    $display("test clock done");
  endtask : t_clock

  task automatic t_blank;
    wr(8'h6c, 8'h01);
    settle;
    chk("red out", 8'h00, dac_red_out);
    chk("green out", 8'h3c, dac_green_out);
    chk("blue out", 8'h00, dac_blue_out);
    wr(8'h6c, 8'h00);
    settle;
    chk("red out", 8'ha5, dac_red_out);
    chk("blue out", 8'h5a, dac_blue_out);
    $display("test blank done");
  endtask : t_blank

  task automatic t_cursor;
    logic [7:0] v [3] = '{8'hae, 8'h5b, 8'h35};
    wr(8'h6d, 8'hff);
    settle;
    chk("cursor fields", 8'h00, cur());
    rd(8'h6d, 8'h00, "cursor reg");
    @(posedge clk_sys);
    host_terminal_function <= 1'b1;
    foreach (v[i]) begin
      wr(8'h6d, v[i]);
      settle;
      chk("cursor fields", v[i][0] ? v[i] : {v[i][7:4], 4'h0}, cur());
    end
    rd(8'h6d, 8'h35, "cursor reg");
    @(posedge clk_sys);
    host_terminal_function <= 1'b0;
    rd(8'h6d, 8'h00, "cursor reg");
    wr(8'h6d, 8'hff);
    settle;
    chk("cursor fields", 8'h35, cur());
    $display("test cursor done");
  endtask : t_cursor

  task automatic t_palette;
    logic [7:0] sq [2][4] = '{'{8'h21, 8'hde, 8'h7b, 8'h00}, '{8'h21, 8'h7b, 8'hde, 8'h00}};
    logic [1:0] el [2][3] = '{'{2'h0, 2'h1, 2'h2}, '{2'h0, 2'h2, 2'h1}};
    wr(8'h62, 8'h21);
    settle;
    rd(8'h67, 8'h21, "red shadow");
    rd(8'h68, 8'hde, "green shadow");
    rd(8'h69, 8'h7b, "blue shadow");
    rd(8'h62, 8'h22, "prefetch index");
    rd(8'h6a, 8'h1d, "sprite prefetch");
    for (int c = 0; c < 4; c++) begin
      wr(8'h66, 8'(c));
      rd(8'h65, sq[0][c], "palette element");
    end
    for (int o = 0; o < 2; o++) begin
      wr(8'h62, 8'h21);
      settle;
      wr(8'h66, {5'h00, o[0], 2'h0});
      for (int k = 0; k < 3 + o; k++) rd(8'h65, sq[o][k], "palette sequence");
      wr(8'h60, 8'h40);
      wr(8'h66, {5'h00, o[0], 2'h0});
      for (int k = 0; k < 3; k++) begin
        wr(8'h65, 8'(8'hc0 + k));
        chk("palette element", {1'b1, 5'h00, el[o][k]}, {pal_we, 5'h00, pal_elem});
        chk("palette addr", 8'h40, pal_addr);
        chk("palette data", 8'(8'hc0 + k), pal_wdata);
      end
    end
    $display("test palette done");
  endtask : t_palette

  task automatic t_shadow;
    logic [7:0] a [4] = '{8'h67, 8'h68, 8'h69, 8'h6b};
    wr(8'h6a, 8'h96);
    chk("sprite strobe", 8'h01, {7'h00, spr_we});
    chk("sprite data", 8'h96, spr_wdata);
    foreach (a[i]) begin
      wr(a[i], ~a[i]);
      rd(a[i], ~a[i], "shadow reg");
    end
    rd(8'h6a, 8'h94, "sprite read");
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00, "unmapped");
    $display("test shadow done");
  endtask : t_shadow

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim;
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    host_terminal_function = 1'b0;
    dac_red_in = 8'ha5;
    dac_green_in = 8'h3c;
    dac_blue_in = 8'h5a;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_clock;
    t_blank;
    t_cursor;
    t_palette;
    t_shadow;
    end_sim;
  end
endmodule : tb_dirb_bank
`default_nettype wire
